//--- brd_pkg.sv
/*
 * constants for the byte register operation datapath: opcodes, flag positions,
 * address formation and q-phase numbering.
 * assumes a single 50 mhz clock where one q phase lasts one clock.
 */
`default_nettype none
package brd_pkg;
    // ------------------------------------------------------------------
    // operation select
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        rotate_right_no_carry_op,
        set_all_ones_op,
        subtract_with_borrow_op,
        nibble_exchange_op
    } brd_op_e;

    // ------------------------------------------------------------------
    // status bit positions (n, ov, z, dc, c)
    // ------------------------------------------------------------------
    localparam int unsigned FLAG_C   = 0;
    localparam int unsigned FLAG_DC  = 1;
    localparam int unsigned FLAG_Z   = 2;
    localparam int unsigned FLAG_OV  = 3;
    localparam int unsigned FLAG_N   = 4;
    localparam logic [4:0]  STATUS_RST = 5'h00;

    // ------------------------------------------------------------------
    // addressing
    // ------------------------------------------------------------------
    localparam logic [7:0]  INDEXED_LIMIT   = 8'h5f;
    localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;
    localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
    localparam logic [7:0]  ALL_ONES        = 8'hff;
    localparam logic [7:0]  W_RST           = 8'h00;
    localparam logic [11:0] ADDR_RST        = 12'h000;
    localparam logic [7:0]  BYTE_RST        = 8'h00;
    localparam logic [4:0]  FLAG_WE_RST     = 5'h00;

    // ------------------------------------------------------------------
    // q phase numbering, one clock per phase
    // ------------------------------------------------------------------
    localparam logic [1:0]  PHASE_Q1 = 2'h0;
    localparam logic [1:0]  PHASE_Q2 = 2'h1;
    localparam logic [1:0]  PHASE_Q3 = 2'h2;
    localparam logic [1:0]  PHASE_Q4 = 2'h3;
endpackage : brd_pkg
`default_nettype wire

//--- brd_alu.sv
/*
 * combinational byte alu for rotate, set, subtract with borrow and swap.
 * assumes operands are held stable by the caller during q3.
 */
`timescale 1ns/1ns
`default_nettype none
module brd_alu (
    input  wire brd_pkg::brd_op_e i_op,      // operation
    input  wire logic [7:0]       i_f,       // file operand
    input  wire logic [7:0]       i_w,       // working register
    input  wire logic             i_carry,   // carry in (1 = no borrow)
    output logic [7:0]            o_result,  // result byte
    output logic [4:0]            o_flags,   // new flag values
    output logic [4:0]            o_flag_we  // flags this op updates
);
    logic [8:0] diff;
    logic [4:0] low_diff;

    always_comb begin
        diff      = {1'b0, i_f} - {1'b0, i_w} - {8'h00, ~i_carry};
        low_diff  = {1'b0, i_f[3:0]} - {1'b0, i_w[3:0]} - {4'h0, ~i_carry};
        o_result  = i_f;
        o_flags   = brd_pkg::STATUS_RST;
        o_flag_we = 5'h00;
        case (i_op)
            brd_pkg::rotate_right_no_carry_op: begin
                o_result = {i_f[0], i_f[7:1]};
                o_flag_we[brd_pkg::FLAG_N] = 1'b1;
                o_flag_we[brd_pkg::FLAG_Z] = 1'b1;
            end
            brd_pkg::set_all_ones_op: begin
                o_result = brd_pkg::ALL_ONES;
            end
            brd_pkg::subtract_with_borrow_op: begin
                o_result = diff[7:0];
                o_flag_we = 5'h1f;
                o_flags[brd_pkg::FLAG_C]  = ~diff[8];
                o_flags[brd_pkg::FLAG_DC] = ~low_diff[4];
                o_flags[brd_pkg::FLAG_OV] = (i_f[7] != i_w[7]) && (diff[7] != i_f[7]);
            end
            brd_pkg::nibble_exchange_op: begin
                o_result = {i_f[3:0], i_f[7:4]};
            end
            default: begin
                o_result = i_f;
            end
        endcase
        o_flags[brd_pkg::FLAG_N] = o_result[7];
        o_flags[brd_pkg::FLAG_Z] = (o_result == 8'h00);
    end
endmodule : brd_alu
`default_nettype wire

//--- brd_datapath.sv
/*
 * execution datapath for four byte-oriented file register operations.
 * it owns the working register and the five status flags.
 * one instruction per four clocks (q1..q4); the data memory is outside and
 * answers a read address combinationally within the q2 clock.
 */
// What this block does
// - rotate right without carry: bit 0 into bit 7, updates n and z only
// - destination bit 0 writes working register, 1 writes file register
// - access bit 0 selects access bank, bank select register ignored
// - access bit 1 forms address from bank select register bank
// - extended set, access 0, address up to 95: indexed literal offset
// - subtract with borrow: f minus w minus not carry; n ov c dc z
// - nibble exchange swaps halves of the byte, flags unchanged
`timescale 1ns/1ns
`default_nettype none
module brd_datapath (
    input  wire logic             i_sys_clk,       // 50 mhz clock
    input  wire logic             i_rstn,          // async reset, active low
    input  wire logic             i_start,         // instruction valid, taken in q1
    input  wire brd_pkg::brd_op_e i_op,            // operation
    input  wire logic [7:0]       i_faddr,         // file address field
    input  wire logic             i_dest,          // destination bit
    input  wire logic             i_access,        // access bit
    input  wire logic [3:0]       i_bank_select_reg, // bank select register
    input  wire logic             i_ext_enable,    // extended instruction set
    input  wire logic [11:0]      i_index_base,    // indexed base pointer
    input  wire logic [7:0]       i_mem_rdata,     // data memory read data
    output logic [11:0]           o_mem_addr,      // data memory address
    output logic                  o_mem_rd,        // read strobe (q2)
    output logic                  o_mem_we,        // write strobe (q4)
    output logic [7:0]            o_mem_wdata,     // write data
    output logic [7:0]            o_w,             // working register
    output logic [4:0]            o_status,        // n ov z dc c
    output logic [1:0]            o_phase,         // current q phase
    output logic                  o_busy           // instruction in progress
);
    // ------------------------------------------------------------------
    // instruction cycle sequencing
    // ------------------------------------------------------------------
    // idle rests in q1; run walks q2, q3, q4 and returns
    typedef enum logic [1:0] {ST_IDLE, ST_RUN} brd_state_e;

    brd_state_e       state, next_state;
    logic [1:0]       phase, next_phase;
    brd_pkg::brd_op_e op, next_op;
    logic             dest, next_dest;
    logic [11:0]      addr, next_addr;
    logic [7:0]       operand, next_operand;
    logic [7:0]       result, next_result;
    logic [4:0]       rflags, next_rflags;
    logic [4:0]       rflag_we, next_rflag_we;
    logic [7:0]       w, next_w;
    logic [4:0]       status, next_status;
    logic [7:0]       mem_wdata, next_mem_wdata;

    // ------------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------------
    logic [11:0]      eff_addr;
    logic [7:0]       alu_result;
    logic [4:0]       alu_flags;
    logic [4:0]       alu_we;
    logic [4:0]       merged_status;

    // ------------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------------
    always_comb begin
        if (i_access) begin
            eff_addr = {i_bank_select_reg, i_faddr};
        // indexed mode takes the low 96 addresses before the access bank does
        end else if (i_ext_enable && (i_faddr <= brd_pkg::INDEXED_LIMIT)) begin
            eff_addr = i_index_base + {4'h0, i_faddr};
        // access bank: addresses below 0x60 general ram, 0x60 and up the top bank
        end else if (i_faddr < brd_pkg::ACCESS_SPLIT) begin
            eff_addr = {brd_pkg::ACCESS_LOW_BANK, i_faddr};
        end else begin
            eff_addr = {brd_pkg::ACCESS_HI_BANK, i_faddr};
        end
    end

    // ------------------------------------------------------------------
    // operation unit
    // ------------------------------------------------------------------
    // operands are registers, so the result settles well inside q3
    brd_alu u_alu (
        .i_op      (op),
        .i_f       (operand),
        .i_w       (w),
        .i_carry   (status[brd_pkg::FLAG_C]),
        .o_result  (alu_result),
        .o_flags   (alu_flags),
        .o_flag_we (alu_we)
    );

    // ------------------------------------------------------------------
    // per-flag merge
    // ------------------------------------------------------------------
    // a flag the operation does not own keeps its value
    generate
        for (genvar gi = 0; gi < 5; gi++) begin : g_flag_merge
            assign merged_status[gi] = rflag_we[gi] ? rflags[gi] : status[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_phase     = phase;
        next_op        = op;
        next_dest      = dest;
        next_addr      = addr;
        next_operand   = operand;
        next_result    = result;
        next_rflags    = rflags;
        next_rflag_we  = rflag_we;
        next_w         = w;
        next_status    = status;
        next_mem_wdata = mem_wdata;
        case (state)
            ST_IDLE: begin
                if (i_start) begin
                    next_state = ST_RUN;
                    next_phase = brd_pkg::PHASE_Q2;
                    next_op    = i_op;
                    // set has no destination bit: it always writes the file
                    next_dest  = (i_op == brd_pkg::set_all_ones_op) ? 1'b1 : i_dest;
                    // address frozen here; later bank changes do not move it
                    next_addr  = eff_addr;
                end
            end
            ST_RUN: begin
                case (phase)
                    brd_pkg::PHASE_Q2: begin
                        // memory answers combinationally; take it at end of q2
                        next_operand = i_mem_rdata;
                        next_phase   = brd_pkg::PHASE_Q3;
                    end
                    brd_pkg::PHASE_Q3: begin
                        // hold result and flags so q4 writes a settled byte
                        next_result    = alu_result;
                        next_rflags    = alu_flags;
                        next_rflag_we  = alu_we;
                        next_mem_wdata = alu_result;
                        next_phase     = brd_pkg::PHASE_Q4;
                    end
                    brd_pkg::PHASE_Q4: begin
                        if (!dest) begin
                            next_w = result;
                        end
                        // w and flags commit together at the end of q4
                        next_status = merged_status;
                        next_state = ST_IDLE;
                        next_phase = brd_pkg::PHASE_Q1;
                    end
                    default: begin
                        next_phase = brd_pkg::PHASE_Q1;
                        next_state = ST_IDLE;
                    end
                endcase
            end
            default: begin
                next_state = ST_IDLE;
                next_phase = brd_pkg::PHASE_Q1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state     <= ST_IDLE;
            phase     <= brd_pkg::PHASE_Q1;
            op        <= brd_pkg::rotate_right_no_carry_op;
            dest      <= 1'b0;
            addr      <= brd_pkg::ADDR_RST;
            operand   <= brd_pkg::BYTE_RST;
            result    <= brd_pkg::BYTE_RST;
            rflags    <= brd_pkg::STATUS_RST;
            rflag_we  <= brd_pkg::FLAG_WE_RST;
            w         <= brd_pkg::W_RST;
            status    <= brd_pkg::STATUS_RST;
            mem_wdata <= brd_pkg::BYTE_RST;
        end else begin
            state     <= next_state;
            phase     <= next_phase;
            op        <= next_op;
            dest      <= next_dest;
            addr      <= next_addr;
            operand   <= next_operand;
            result    <= next_result;
            rflags    <= next_rflags;
            rflag_we  <= next_rflag_we;
            w         <= next_w;
            status    <= next_status;
            mem_wdata <= next_mem_wdata;
        end
    end

    // ------------------------------------------------------------------
    // data memory interface
    // ------------------------------------------------------------------
    // strobes decode registered state only; no input reaches them
    assign o_mem_addr  = addr;
    assign o_mem_rd    = (state == ST_RUN) && (phase == brd_pkg::PHASE_Q2);
    assign o_mem_we    = (state == ST_RUN) && (phase == brd_pkg::PHASE_Q4) && dest;
    assign o_mem_wdata = mem_wdata;

    // ------------------------------------------------------------------
    // core state view
    // ------------------------------------------------------------------
    assign o_w         = w;
    assign o_status    = status;
    assign o_phase     = phase;
    assign o_busy      = (state == ST_RUN);
endmodule : brd_datapath
`default_nettype wire

//--- brd_mem_model.sv
/* data memory model for the datapath bench.
   assumes the read strobe asks for a combinational answer. */
`timescale 1ns/1ns
`default_nettype none
module brd_mem_model (
    input  wire logic        i_sys_clk, // clock
    input  wire logic [11:0] i_addr,    // address
    input  wire logic        i_rd,      // read strobe
    input  wire logic        i_we,      // write strobe
    input  wire logic [7:0]  i_wdata,   // write data
    output logic [7:0]       o_rdata    // read data
);
    logic [7:0] mem [4096];
    logic [7:0] last = 8'h00;
    // released bus shows the inverse of the last byte
    assign o_rdata = i_rd ? mem[i_addr] : ~last;
    always @(posedge i_sys_clk) begin
        if (i_rd) last <= mem[i_addr];
        if (i_we) mem[i_addr] <= i_wdata;
    end
endmodule : brd_mem_model
`default_nettype wire

//--- brd_datapath_monitor.sv
/* port checker for brd_datapath.
   bound to every brd_datapath instance. */
`timescale 1ns/1ns
`default_nettype none
module brd_datapath_monitor (
    input wire logic             i_sys_clk,         // clock
    input wire logic             i_rstn,            // reset
    input wire logic             i_start,           // start
    input wire brd_pkg::brd_op_e i_op,              // operation
    input wire logic [7:0]       i_faddr,           // file address
    input wire logic             i_dest,            // destination
    input wire logic             i_access,          // access bit
    input wire logic [3:0]       i_bank_select_reg, // bank
    input wire logic             i_ext_enable,      // extended set
    input wire logic [11:0]      i_index_base,      // index base
    input wire logic [7:0]       i_mem_rdata,       // read data
    input wire logic [11:0]      o_mem_addr,        // address
    input wire logic             o_mem_rd,          // read strobe
    input wire logic             o_mem_we,          // write strobe
    input wire logic [7:0]       o_mem_wdata,       // write data
    input wire logic [7:0]       o_w,               // working reg
    input wire logic [4:0]       o_status,          // flags
    input wire logic [1:0]       o_phase,           // phase
    input wire logic             o_busy             // busy
);
    logic take, t_rot, t_set, t_swp, wr_file, idx;
    assign take    = i_start && !o_busy;
    assign t_rot   = take && i_op == brd_pkg::rotate_right_no_carry_op;
    assign t_set   = take && i_op == brd_pkg::set_all_ones_op;
    assign t_swp   = take && i_op == brd_pkg::nibble_exchange_op;
    assign wr_file = i_dest || i_op == brd_pkg::set_all_ones_op;
    assign idx     = !i_access && i_ext_enable && i_faddr <= 8'h5f;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    chk_busy_span: assert property (take |=> o_busy [*3] ##1 !o_busy)
        else $error("busy span wrong");
    chk_read_q2: assert property (take |=> o_mem_rd && o_phase == 2'h1)
        else $error("read strobe not in q2");
    chk_write_dest: assert property (take |-> ##3 o_mem_we == $past(wr_file, 3))
        else $error("write strobe wrong");
    chk_w_dest: assert property (take && !wr_file |-> ##4 o_w == o_mem_wdata)
        else $error("working register not loaded");
    chk_set_ones: assert property (t_set |-> ##3 o_mem_wdata == 8'hff)
        else $error("set result not all ones");
    chk_flags_kept: assert property ((t_swp || t_set) |-> ##4
        o_status == $past(o_status, 4)) else $error("flags changed");
    chk_rotate_res: assert property (t_rot |-> ##3 o_mem_wdata ==
        (($past(i_mem_rdata, 2) >> 1) | ($past(i_mem_rdata, 2) << 7))) else $error("rotate wrong");
    chk_swap_res: assert property (t_swp |-> ##3 o_mem_wdata ==
        (($past(i_mem_rdata, 2) << 4) | ($past(i_mem_rdata, 2) >> 4))) else $error("swap wrong");
    chk_bank_addr: assert property (take && i_access |=>
        o_mem_addr == {$past(i_bank_select_reg), $past(i_faddr)})
        else $error("bank address wrong");
    chk_access_bank: assert property (take && !i_access && !idx |=> o_mem_addr ==
        {($past(i_faddr) < 8'h60) ? 4'h0 : 4'hf, $past(i_faddr)}) else $error("access bank wrong");
    chk_indexed_addr: assert property (take && idx |=>
        o_mem_addr == $past(i_index_base) + {4'h0, $past(i_faddr)}) else $error("indexed wrong");
    chk_rotate_flags: assert property (t_rot |-> ##4 (o_status & 5'h0b) ==
        ($past(o_status, 4) & 5'h0b)) else $error("rotate changed other flags");
    chk_we_phase: assert property (o_mem_we |-> o_phase == 2'h3)
        else $error("write strobe outside q4");
endmodule : brd_datapath_monitor
bind brd_datapath brd_datapath_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_start(i_start), .i_op(i_op), .i_faddr(i_faddr), .i_dest(i_dest), .i_access(i_access),
    .i_bank_select_reg(i_bank_select_reg), .i_ext_enable(i_ext_enable),
    .i_index_base(i_index_base), .i_mem_rdata(i_mem_rdata), .o_mem_addr(o_mem_addr),
    .o_mem_rd(o_mem_rd), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_w(o_w),
    .o_status(o_status), .o_phase(o_phase), .o_busy(o_busy));
`default_nettype wire

//--- brd_datapath_tb_top.sv
/* self-checking bench for brd_datapath with a data memory model.
   assumes package, design, model and checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module brd_datapath_tb_top;
    logic             clk = 1'b0, rstn = 1'b0, start = 1'b0, dest = 1'b0, acc = 1'b0, ext = 1'b0;
    brd_pkg::brd_op_e op = brd_pkg::set_all_ones_op;
    logic [7:0]       fa = 8'h00, rdata, wdata, w;
    logic [3:0]       bank_select_reg = 4'h0;
    logic [11:0]      base = 12'h000, addr;
    logic             rd, we, busy;
    logic [4:0]       st;
    logic [1:0]       ph;
    int               mismatches = 0, n_compared = 0;
    always #10 clk = ~clk;
    brd_datapath dut (.i_sys_clk(clk), .i_rstn(rstn), .i_start(start), .i_op(op),
        .i_faddr(fa), .i_dest(dest), .i_access(acc), .i_bank_select_reg(bank_select_reg),
        .i_ext_enable(ext), .i_index_base(base), .i_mem_rdata(rdata), .o_mem_addr(addr),
        .o_mem_rd(rd), .o_mem_we(we), .o_mem_wdata(wdata), .o_w(w), .o_status(st),
        .o_phase(ph), .o_busy(busy));
    brd_mem_model mem (.i_sys_clk(clk), .i_addr(addr), .i_rd(rd), .i_we(we),
        .i_wdata(wdata), .o_rdata(rdata));
    // ----------------
    // shared tasks
    // ----------------
    task automatic wrap_up;
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected byte at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected flags at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk5
    task automatic run(input brd_pkg::brd_op_e o, input logic [7:0] f, input logic d,
                       input logic a, input logic [3:0] b, input logic e);
        @(posedge clk);
        op <= o;
        fa <= f;
        dest <= d;
        acc <= a;
        bank_select_reg <= b;
        ext <= e;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : run
    task automatic load_w(input logic [7:0] v, input logic [4:0] s);
        mem.mem[12'h3ff] = {v[3:0], v[7:4]};
        run(brd_pkg::nibble_exchange_op, 8'hff, 1'b0, 1'b1, 4'h3, 1'b0);
        chk8(w, v);
        chk5(st, s);
    endtask : load_w
    task automatic sub_f(input logic [7:0] f, v, input logic d, input logic [7:0] r,
                         input logic [4:0] s);
        mem.mem[{4'h3, f}] = v;
        run(brd_pkg::subtract_with_borrow_op, f, d, 1'b1, 4'h3, 1'b0);
        chk8(d ? mem.mem[{4'h3, f}] : w, r);
        chk5(st, s);
    endtask : sub_f
    // ----------------
    // scenarios
    // ----------------
    task automatic t_rotate;
        mem.mem[12'h020] = 8'hd7;
        mem.mem[12'hfe0] = 8'h00;
        run(brd_pkg::rotate_right_no_carry_op, 8'h20, 1'b1, 1'b0, 4'h7, 1'b0);
        chk8(mem.mem[12'h020], 8'heb);
        chk5(st, 5'h10);
        run(brd_pkg::rotate_right_no_carry_op, 8'h20, 1'b0, 1'b0, 4'h7, 1'b0);
        chk8(w, 8'hf5);
        chk8(mem.mem[12'h020], 8'heb);
        run(brd_pkg::rotate_right_no_carry_op, 8'he0, 1'b1, 1'b0, 4'h7, 1'b0);
        chk5(st, 5'h04);
    endtask : t_rotate
    task automatic t_subtract;
        load_w(8'h1a, 5'h04);
        sub_f(8'h1b, 8'h1b, 1'b0, 8'h00, 5'h07);
        load_w(8'h0d, 5'h07);
        sub_f(8'h19, 8'h19, 1'b1, 8'h0c, 5'h01);
        load_w(8'h0e, 5'h01);
        sub_f(8'h03, 8'h03, 1'b1, 8'hf5, 5'h10);
        load_w(8'h01, 5'h10);
        sub_f(8'h80, 8'h80, 1'b1, 8'h7e, 5'h09);
    endtask : t_subtract
    task automatic t_indexed;
        mem.mem[12'h15f] = 8'h00;
        mem.mem[12'h05f] = 8'h5a;
        mem.mem[12'hf60] = 8'h00;
        @(posedge clk) base <= 12'h100;
        run(brd_pkg::set_all_ones_op, 8'h5f, 1'b0, 1'b0, 4'h9, 1'b1);
        chk8(mem.mem[12'h15f], 8'hff);
        chk8(mem.mem[12'h05f], 8'h5a);
        chk5(st, 5'h09);
        run(brd_pkg::set_all_ones_op, 8'h60, 1'b0, 1'b0, 4'h9, 1'b1);
        chk8(mem.mem[12'hf60], 8'hff);
        run(brd_pkg::rotate_right_no_carry_op, 8'h60, 1'b0, 1'b0, 4'h9, 1'b1);
        chk8(w, 8'hff);
        chk5(st, 5'h19);
    endtask : t_indexed
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_rotate;
        t_subtract;
        t_indexed;
        wrap_up;
    end
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        wrap_up;
    end
endmodule : brd_datapath_tb_top
`default_nettype wire
